// ==== src/fsbw_map.svh ====
`ifndef FSBW_MAP_SVH
`define FSBW_MAP_SVH
// clock rate and millisecond tick
`define FSBW_CLK_HZ 40000000
`define FSBW_MS_PER_S 1000
`define FSBW_MS_CYCLES (`FSBW_CLK_HZ / `FSBW_MS_PER_S)
// parameter defaults and limits
`define FSBW_BRAKE_TIME_DEF 15'h0000
`define FSBW_BRAKE_TIME_MAX 15'h7530
`define FSBW_STEP_LIMIT_DEF 12'h3E8
`define FSBW_STEP_LIMIT_MAX 12'hBB8
`define FSBW_SPEED_CEIL_DEF 6'h32
`define FSBW_SPEED_CEIL_MAX 6'h32
`define FSBW_COMM_TIMEOUT_DEF 14'h01F4
`define FSBW_COMM_TIMEOUT_MAX 14'h2710
`define FSBW_COMM_ACTION_DEF 5'h01
`define FSBW_COMM_ACTION_MIN 5'h01
`define FSBW_COMM_ACTION_MAX 5'h10
`define FSBW_ZERO_THR_DEF 6'h00
`define FSBW_STOP_SEQ_DEF 2'h0
// stop-sequence selector bits
`define FSBW_SEQ_DECEL_BIT 1
`define FSBW_SEQ_AFTER_BIT 0
`endif

// ==== src/fsbw_pkg.sv ====
package fsbw_pkg;
  typedef enum logic [1:0] {
    FSBW_IDLE,
    FSBW_DECEL,
    FSBW_STOPPED
  } fsbw_stop_t;

  function automatic logic [14:0] fsbw_clamp15(input logic [14:0] v, input logic [14:0] mx);
    fsbw_clamp15 = (v > mx) ? mx : v;
  endfunction
endpackage

// ==== src/fsbw_ms_tick.sv ====
`timescale 1ns/1ps
`include "fsbw_map.svh"
module fsbw_ms_tick (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // one-cycle pulse per millisecond
  output logic tick_q
);
  localparam logic [15:0] LAST = 16'(`FSBW_MS_CYCLES - 1);
  logic [15:0] cnt_q;

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      cnt_q <= 16'h0000;
      tick_q <= 1'b0;
    end else if (cnt_q == LAST) begin
      cnt_q <= 16'h0000;
      tick_q <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 16'h0001;
      tick_q <= 1'b0;
    end
  end
endmodule // fsbw_ms_tick

// ==== src/fsbw_comm_watchdog.sv ====
`timescale 1ns/1ps
`include "fsbw_map.svh"
module fsbw_comm_watchdog (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic ms_tick,
  // configuration
  input wire logic [13:0] timeout_ms,
  // message arrival
  input wire logic msg_rx,
  // expiry pulse
  output logic expire_q
);
  logic [13:0] timer_q;
  logic armed_q;

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      timer_q <= `FSBW_COMM_TIMEOUT_DEF;
      armed_q <= 1'b0;
      expire_q <= 1'b0;
    end else begin
      expire_q <= 1'b0;
      if (msg_rx) begin
        timer_q <= timeout_ms;
        armed_q <= 1'b1;
      end else if (armed_q && ms_tick) begin
        if (timer_q <= 14'h0001) begin
          timer_q <= 14'h0000;
          armed_q <= 1'b0;
          expire_q <= 1'b1;
        end else begin
          timer_q <= timer_q - 14'h0001;
        end
      end
    end
  end
endmodule // fsbw_comm_watchdog

// ==== src/fsbw_fault_stop.sv ====
`timescale 1ns/1ps
`include "fsbw_map.svh"
// Contract
// - brake action time limit in ms, 0 to 30000, default 0, used after a fault.
// - braking deceleration ends at zero speed or when the time limit is reached.
// - past the time limit the brake is released even if speed is still high; with seq_q[0] set the code re-engages it at or below the ceiling.
// - current step limit in 0.1 percent, default 1000, up to 3000.
// - a demand step above the limit raises a collision fault and disables the motor.
// - brake speed ceiling in rps, 0 to 50, default 50.
// - the brake engages only once speed is at or below the ceiling.
// - communication timeout in ms, 0 to 10000, default 500.
// - each application message reloads the watchdog which then counts down.
// - at zero the selected action (1 to 16, default 1) is started.
module fsbw_fault_stop
  import fsbw_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // configuration
  input wire logic [14:0] brake_time_limit_param,
  input wire logic [5:0] zero_speed_threshold_param,
  input wire logic [11:0] current_step_limit_param,
  input wire logic [5:0] brake_speed_ceiling_param,
  input wire logic [13:0] comm_timeout_param,
  input wire logic [4:0] comm_loss_action_param,
  input wire logic [1:0] stop_seq_sel,
  // parameter load strobe
  input wire logic param_load,
  // drive status
  input wire logic fault_in,
  input wire logic fault_clear,
  input wire logic [5:0] motor_speed,
  // current loop demand, 0.1 percent, signed
  input wire logic demand_valid,
  input wire logic signed [12:0] current_demand,
  // network
  input wire logic msg_rx,
  // outputs
  output logic dyn_brake_q,
  output logic collision_fault_q,
  output logic motor_disable_q,
  output logic braking_active_q,
  output logic comm_loss_q,
  output logic [4:0] comm_loss_action_q
);
  // ----------------------------------------
  // range helpers
  // ----------------------------------------
  // speed at or below a limit
  function automatic logic fsbw_at_or_below(input logic [5:0] spd, input logic [5:0] lim);
    fsbw_at_or_below = (spd <= lim);
  endfunction

  // saturate a speed setting
  function automatic logic [5:0] fsbw_clamp6(input logic [5:0] v, input logic [5:0] mx);
    fsbw_clamp6 = (v > mx) ? mx : v;
  endfunction

  // hold an action code inside its window
  function automatic logic [4:0] fsbw_window5(input logic [4:0] v, input logic [4:0] lo,
                                              input logic [4:0] hi);
    if (v < lo) begin
      fsbw_window5 = lo;
    end else if (v > hi) begin
      fsbw_window5 = hi;
    end else begin
      fsbw_window5 = v;
    end
  endfunction

  // magnitude of a signed demand step
  function automatic logic [13:0] fsbw_abs14(input logic signed [13:0] v);
    fsbw_abs14 = v[13] ? 14'(-v) : 14'(v);
  endfunction

  // ----------------------------------------
  // stored parameters
  // ----------------------------------------
  logic [14:0] brake_time_q;
  logic [11:0] step_limit_q;
  logic [5:0] speed_ceil_q;
  logic [13:0] comm_timeout_q;
  logic [4:0] action_sel_q;
  logic [5:0] zero_thr_q;
  logic [1:0] seq_q;

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      brake_time_q <= `FSBW_BRAKE_TIME_DEF;
      speed_ceil_q <= `FSBW_SPEED_CEIL_DEF;
      zero_thr_q <= `FSBW_ZERO_THR_DEF;
      seq_q <= `FSBW_STOP_SEQ_DEF;
    end else if (param_load) begin
      brake_time_q <= fsbw_clamp15(brake_time_limit_param, `FSBW_BRAKE_TIME_MAX);
      speed_ceil_q <= fsbw_clamp6(brake_speed_ceiling_param, `FSBW_SPEED_CEIL_MAX);
      zero_thr_q <= zero_speed_threshold_param;
      seq_q <= stop_seq_sel;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      step_limit_q <= `FSBW_STEP_LIMIT_DEF;
    end else if (param_load) begin
      step_limit_q <= 12'(fsbw_clamp15(15'(current_step_limit_param),
                                        15'(`FSBW_STEP_LIMIT_MAX)));
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      comm_timeout_q <= `FSBW_COMM_TIMEOUT_DEF;
      action_sel_q <= `FSBW_COMM_ACTION_DEF;
    end else if (param_load) begin
      comm_timeout_q <= 14'(fsbw_clamp15(15'(comm_timeout_param),
                                          15'(`FSBW_COMM_TIMEOUT_MAX)));
      action_sel_q <= fsbw_window5(comm_loss_action_param, `FSBW_COMM_ACTION_MIN,
                                   `FSBW_COMM_ACTION_MAX);
    end
  end

  // ----------------------------------------
  // millisecond time base
  // ----------------------------------------
  logic ms_tick;

  fsbw_ms_tick u_tick (
    .clk_sys(clk_sys),
    .reset(reset),
    .tick_q(ms_tick)
  );

  // ----------------------------------------
  // post-fault stop sequence
  // ----------------------------------------
  fsbw_stop_t state_q;
  logic [14:0] elapsed_q;
  logic fault_d1_q;
  logic at_zero;
  logic time_up;
  logic below_ceil;

  // speed and elapsed-time tests
  assign at_zero = fsbw_at_or_below(motor_speed, zero_thr_q);
  assign time_up = (elapsed_q >= brake_time_q);
  assign below_ceil = fsbw_at_or_below(motor_speed, speed_ceil_q);

  // previous fault level, edge detect
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      fault_d1_q <= 1'b0;
    end else begin
      fault_d1_q <= fault_in;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      state_q <= FSBW_IDLE;
    end else begin
      case (state_q)
        FSBW_IDLE: begin
          if (fault_in && !fault_d1_q) begin
            state_q <= FSBW_DECEL;
          end
        end
        FSBW_DECEL: begin
          if (at_zero || time_up) begin
            state_q <= FSBW_STOPPED;
          end
        end
        FSBW_STOPPED: begin
          if (fault_clear) begin
            state_q <= FSBW_IDLE;
          end
        end
        default: begin
          state_q <= FSBW_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      elapsed_q <= 15'h0000;
    end else if (state_q != FSBW_DECEL) begin
      elapsed_q <= 15'h0000;
    end else if (ms_tick && elapsed_q != 15'h7FFF) begin
      elapsed_q <= elapsed_q + 15'h0001;
    end
  end

  // ----------------------------------------
  // stop outputs
  // ----------------------------------------
  // decel indication
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      braking_active_q <= 1'b0;
    end else begin
      braking_active_q <= (state_q == FSBW_DECEL);
    end
  end

  // selector decode, speed ceiling, timed release
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      dyn_brake_q <= 1'b0;
    end else begin
      case (state_q)
        FSBW_DECEL: begin
          dyn_brake_q <= seq_q[`FSBW_SEQ_DECEL_BIT] && below_ceil && !time_up;
        end
        FSBW_STOPPED: begin
          dyn_brake_q <= seq_q[`FSBW_SEQ_AFTER_BIT] && below_ceil;
        end
        default: begin
          dyn_brake_q <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------
  // collision detection
  // ----------------------------------------
  logic signed [12:0] prev_demand_q;
  logic prev_valid_q;
  logic signed [13:0] step;
  logic [13:0] step_abs;
  logic step_trip;

  assign step = 14'(current_demand) - 14'(prev_demand_q);
  assign step_abs = fsbw_abs14(step);
  assign step_trip = demand_valid && prev_valid_q && (step_abs > 14'(step_limit_q));

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      prev_demand_q <= 13'h0000;
      prev_valid_q <= 1'b0;
    end else if (demand_valid) begin
      prev_demand_q <= current_demand;
      prev_valid_q <= 1'b1;
    end
  end

  // collision fault, set wins over clear
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      collision_fault_q <= 1'b0;
    end else if (step_trip) begin
      collision_fault_q <= 1'b1;
    end else if (fault_clear) begin
      collision_fault_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      motor_disable_q <= 1'b0;
    end else begin
      motor_disable_q <= collision_fault_q || (state_q != FSBW_IDLE);
    end
  end

  // ----------------------------------------
  // communication watchdog
  // ----------------------------------------
  logic wd_expire;

  fsbw_comm_watchdog u_wd (
    .clk_sys(clk_sys),
    .reset(reset),
    .ms_tick(ms_tick),
    .timeout_ms(comm_timeout_q),
    .msg_rx(msg_rx),
    .expire_q(wd_expire)
  );

  // ----------------------------------------
  // communication loss action
  // ----------------------------------------
  // latch selected action, set wins
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      comm_loss_q <= 1'b0;
      comm_loss_action_q <= `FSBW_COMM_ACTION_DEF;
    end else if (wd_expire) begin
      comm_loss_q <= 1'b1;
      comm_loss_action_q <= action_sel_q;
    end else if (msg_rx || fault_clear) begin
      comm_loss_q <= 1'b0;
    end
  end
endmodule // fsbw_fault_stop

// ==== verification/fsbw_fault_stop_props.sv ====
`timescale 1ns/1ps
module fsbw_fault_stop_props (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // inputs
  input wire logic [5:0] brake_speed_ceiling_param,
  input wire logic [1:0] stop_seq_sel,
  input wire logic fault_in,
  input wire logic fault_clear,
  input wire logic [5:0] motor_speed,
  input wire logic msg_rx,
  // outputs
  input wire logic dyn_brake_q,
  input wire logic collision_fault_q,
  input wire logic motor_disable_q,
  input wire logic braking_active_q,
  input wire logic comm_loss_q,
  input wire logic [4:0] comm_loss_action_q
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  property p_coll_dis;
    collision_fault_q |-> ##1 motor_disable_q;
  endproperty
  a_coll_dis: assert property (p_coll_dis) else $error("collision without disable");
  property p_coll_hold;
    collision_fault_q && !fault_clear |=> collision_fault_q;
  endproperty
  a_coll_hold: assert property (p_coll_hold) else $error("collision flag dropped");
  property p_fault_stop;
    $rose(fault_in) && !motor_disable_q && !fault_clear |-> ##2 motor_disable_q;
  endproperty
  a_fault_stop: assert property (p_fault_stop) else $error("fault did not stop");
  property p_ceil;
    dyn_brake_q |-> $past(motor_speed) <= brake_speed_ceiling_param;
  endproperty
  a_ceil: assert property (p_ceil) else $error("brake above ceiling");
  property p_brake_seq;
    dyn_brake_q |-> motor_disable_q;
  endproperty
  a_brake_seq: assert property (p_brake_seq) else $error("brake outside stop");
  property p_after_sel;
    !braking_active_q && motor_disable_q && !stop_seq_sel[0] |-> !dyn_brake_q;
  endproperty
  a_after_sel: assert property (p_after_sel) else $error("brake after stop");
  property p_wd_code;
    $rose(comm_loss_q) |-> comm_loss_action_q inside {[5'h01:5'h10]};
  endproperty
  a_wd_code: assert property (p_wd_code) else $error("action code range");
  property p_wd_hold;
    comm_loss_q && !fault_clear && !msg_rx |=> comm_loss_q;
  endproperty
  a_wd_hold: assert property (p_wd_hold) else $error("loss flag dropped");
  c_coll: cover property ($rose(collision_fault_q));
  c_loss: cover property ($rose(comm_loss_q));
  c_brake: cover property ($rose(dyn_brake_q));
endmodule // fsbw_fault_stop_props

// ==== verification/fsbw_net_master.sv ====
`timescale 1ns/1ps
module fsbw_net_master #(
  parameter int GAP = 1000
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // keepalive enable
  input wire logic run,
  // message pulse
  output logic msg_rx
);
  logic [15:0] gap_q;
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      gap_q <= 16'h0000;
      msg_rx <= 1'b0;
    end else begin
      msg_rx <= run && (gap_q == 16'h0000);
      gap_q <= (gap_q == 16'h0000) ? 16'(GAP) : gap_q - 16'h0001;
    end
  end
endmodule // fsbw_net_master

// ==== verification/fsbw_fault_stop_tb_top.sv ====
`timescale 1ns/1ps
module fsbw_fault_stop_tb_top;
  logic clk_sys = 1'b0, reset = 1'b1, param_load = 1'b0, fault_in = 1'b0;
  logic fault_clear = 1'b0, demand_valid = 1'b0, run = 1'b0;
  logic [14:0] bt = 15'h0000;
  logic [5:0] zt = 6'h00, sc = 6'h32, spd = 6'h00;
  logic [13:0] ct = 14'h01F4;
  logic [4:0] ca = 5'h01, act;
  logic [1:0] ss = 2'h0;
  logic [12:0] dem = 13'h0000;
  logic [11:0] sl = 12'h3E8;
  logic msg_rx, dyn, col, dis, brk, cl;
  int n_errors = 0, n_compared = 0;
  always #12.5 clk_sys = ~clk_sys;
  fsbw_net_master fsbw_net_master_inst (.clk_sys, .reset, .run, .msg_rx);
  fsbw_fault_stop fsbw_fault_stop_inst (.clk_sys, .reset, .brake_time_limit_param(bt),
    .zero_speed_threshold_param(zt), .current_step_limit_param(sl),
    .brake_speed_ceiling_param(sc), .comm_timeout_param(ct), .comm_loss_action_param(ca),
    .stop_seq_sel(ss), .param_load, .fault_in, .fault_clear, .motor_speed(spd),
    .demand_valid, .current_demand(dem), .msg_rx, .dyn_brake_q(dyn),
    .collision_fault_q(col), .motor_disable_q(dis), .braking_active_q(brk),
    .comm_loss_q(cl), .comm_loss_action_q(act));
  task step(input int n);
    repeat (n) @(posedge clk_sys);
    #2;
  endtask
  task chk(input logic [4:0] g, input logic [4:0] e);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value at %0t: got %0h expected %0h", $time, g, e);
    end
  endtask
  task load(input logic [14:0] t, input logic [5:0] c, input logic [1:0] s,
            input logic [13:0] w, input logic [4:0] a);
    bt = t; sc = c; zt = 6'h03; ss = s; ct = w; ca = a;
    param_load = 1'b1;
    step(1);
    param_load = 1'b0;
  endtask
  task dmd(input logic [12:0] v);
    dem = v;
    demand_valid = 1'b1;
    step(1);
    demand_valid = 1'b0;
    step(1);
  endtask
  task clr;
    fault_in = 1'b0;
    fault_clear = 1'b1;
    step(1);
    fault_clear = 1'b0;
    step(2);
  endtask
  task print_verdict;
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #2500000;
    n_errors++;
    print_verdict;
  end
  initial begin
    step(5);
    reset = 1'b0;
    step(1);
    chk(act, 5'h01);
    chk({dis, col, cl, dyn, brk}, 5'h00);
    dmd(13'h0000);
    dmd(13'h03E8);
    chk(col, 5'h00);
    dmd(13'h07D1);
    step(1);
    chk({col, dis}, 5'h03);
    clr;
    chk({col, dis}, 5'h00);
    load(15'h0005, 6'h14, 2'h3, 14'h01F4, 5'h01);
    spd = 6'h1E;
    fault_in = 1'b1;
    step(3);
    chk({brk, dis, dyn}, 5'h06);
    spd = 6'h0A;
    step(3);
    chk(dyn, 5'h01);
    spd = 6'h02;
    step(4);
    chk({brk, dyn}, 5'h01);
    clr;
    chk({dis, dyn}, 5'h00);
    load(15'h0001, 6'h14, 2'h2, 14'h0002, 5'h14);
    spd = 6'h0A;
    run = 1'b1;
    step(2);
    fault_in = 1'b1;
    step(4);
    chk(dyn, 5'h01);
    repeat (42000) if (brk) step(1);
    chk({brk, dyn, dis, cl}, 5'h02);
    run = 1'b0;
    repeat (82000) if (!cl) step(1);
    chk(5'(cl), 5'h01);
    chk(act, 5'h10);
    run = 1'b1;
    step(1010);
    chk(cl, 5'h00);
    sl = 12'hFFF;
    load(15'h0001, 6'h14, 2'h2, 14'h0002, 5'h14);
    dmd(13'h0000);
    dmd(13'h0BB8);
    chk(col, 5'h00);
    dmd(13'h1FFF);
    chk(col, 5'h01);
    fault_in = 1'b0;
    reset = 1'b1;
    step(2);
    reset = 1'b0;
    step(1);
    chk({dis, col, cl, dyn, brk}, 5'h00);
    chk(act, 5'h01);
    dmd(13'h0000);
    dmd(13'h03E9);
    chk(col, 5'h01);
    print_verdict;
  end
endmodule // fsbw_fault_stop_tb_top
bind fsbw_fault_stop fsbw_fault_stop_props fsbw_fault_stop_props_inst (.clk_sys, .reset,
  .brake_speed_ceiling_param, .stop_seq_sel, .fault_in, .fault_clear, .motor_speed, .msg_rx,
  .dyn_brake_q, .collision_fault_q, .motor_disable_q, .braking_active_q, .comm_loss_q,
  .comm_loss_action_q);
